// File: hdl/rbs_sequencer.sv
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter longint unsigned POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_MAX_CYC,
  parameter int unsigned EXEC_CYCLES = EXEC_DELAY_CYC
) (
  // clock and power-on reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  // analog monitors and pin
  input wire logic POR_ACTIVE,
  input wire logic UV_BELOW_FILTERED,
  input wire logic UV_DET_READY,
  input wire logic EXTERNAL_RESET_PIN_N,
  // internal reset requests (pulses or levels) and sleep
  input wire logic WDT_RESET,
  input wire logic RESET_INSTR,
  input wire logic STACK_OVERFLOW,
  input wire logic STACK_UNDERFLOW,
  input wire logic PROG_MODE,
  input wire logic SLEEP,
  // configuration
  input wire logic [MODE_W-1:0] UNDERVOLTAGE_MODE_SELECT,
  input wire logic [LEVEL_W-1:0] UNDERVOLTAGE_LEVEL_SELECT,
  input wire logic [SEL_W-1:0] POWER_UP_DELAY_SELECT,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // analog detector control
  output logic UV_DET_ENABLE,
  output logic [LEVEL_W-1:0] UV_LEVEL,
  // core side
  output logic CORE_RESET_N,
  output logic CORE_RUN
);
  // ****************************************
  // synchronised inputs
  // ****************************************
  rbs_sync_if #(.WIDTH(4)) sif ();
  // pin enters inverted so the chain's reset value means released; otherwise
  // every power-on release would see a false pin reset for two cycles
  assign sif.raw = {~EXTERNAL_RESET_PIN_N, UV_DET_READY, UV_BELOW_FILTERED, POR_ACTIVE};
  rbs_sync u_sync (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .ce(CE),
    .sig(sif.syn)
  );
  wire pin_n_s = ~sif.synced[3];
  wire ready_s = sif.synced[2];
  wire below_s = sif.synced[1];
  wire por_s = sif.synced[0];

  // ****************************************
  // registers and state
  // ****************************************
  rbs_state_t state_ff, nxt_state;
  logic soft_en_ff;
  logic uv_flag_ff;
  logic por_flag_ff;
  logic prog_ff;
  logic waking_ff;
  logic [3:0] exec_cnt_ff;
  logic rd_valid_ff;
  logic [31:0] rdata_ff;

  // ****************************************
  // mode decode
  // ****************************************
  wire mode_on = UNDERVOLTAGE_MODE_SELECT == MODE_ALWAYS_ON;
  wire mode_slp = UNDERVOLTAGE_MODE_SELECT == MODE_OFF_SLEEP;
  wire mode_sw = UNDERVOLTAGE_MODE_SELECT == MODE_SOFTWARE;
  // detector powered: always-on forced, off-in-sleep only awake, sw by bit
  wire det_en = mode_on | (mode_slp & ~SLEEP) | (mode_sw & soft_en_ff);
  // protection only once the detector is ready
  wire prot_active = det_en & ready_s;
  wire uv_trip = prot_active & below_s;
  wire prog_exit = prog_ff & ~PROG_MODE;
  wire power_event = por_s | uv_trip | prog_exit | PROG_MODE;
  wire other_src = WDT_RESET | RESET_INSTR | STACK_OVERFLOW | STACK_UNDERFLOW | ~pin_n_s;
  wire power_up_delay_timer_en = POWER_UP_DELAY_SELECT != POWER_UP_DELAY_TIMER_DISABLED;
  // start-up waits for detector only in the forced-on and off-in-sleep modes
  wire start_ok = (mode_on | mode_slp) ? (ready_s & ~below_s) : 1'b1;
  // wake from sleep waits only in off-in-sleep mode
  wire wake_ok = mode_slp ? (ready_s & ~below_s) : 1'b1;
  wire power_up_delay_timer_busy;
  wire power_up_delay_timer_start = (state_ff == ST_HOLD) & ~power_event & power_up_delay_timer_en;

  // ****************************************
  // power-up delay timer
  // ****************************************
  rbs_timer #(.CW(36)) u_power_up_delay_timer (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .ce(CE),
    .start(power_up_delay_timer_start),
    .load(POWER_UP_DELAY_TIMER_CYCLES[35:0]),
    .busy(power_up_delay_timer_busy)
  );

  // ****************************************
  // sequencer next state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_HOLD: begin
        if (!power_event) begin
          nxt_state = power_up_delay_timer_en ? ST_POWER_UP_DELAY_TIMER : ST_WAIT;
        end
      end
      ST_POWER_UP_DELAY_TIMER: begin
        if (!power_up_delay_timer_busy) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (pin_n_s && start_ok && exec_cnt_ff == 4'(EXEC_CYCLES - 1)) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
    endcase
    // power events restart the whole sequence; other sources only pull
    // wait or run back, so the delay timer is never cut short by them
    if (power_event) begin
      nxt_state = ST_HOLD;
    end else if (other_src && (state_ff == ST_WAIT || state_ff == ST_RUN)) begin
      nxt_state = ST_WAIT;
    end
  end

  // state register
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_HOLD;
    end else if (CE) begin
      state_ff <= nxt_state;
    end
  end

  // execution delay counter: counts while pin released and start allowed
  wire cnt_go = (state_ff == ST_WAIT) & pin_n_s & start_ok & ~other_src & ~power_event;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      exec_cnt_ff <= 4'h0;
    end else if (CE) begin
      exec_cnt_ff <= cnt_go ? exec_cnt_ff + 4'h1 : 4'h0;
    end
  end

  // ****************************************
  // status flags, programming tracking and soft enable
  // ****************************************
  // flags low-active in spirit: 0 means that reset happened; software sets back
  wire wr_ctrl = AVS_WRITE & (AVS_ADDRESS == ADDR_CTRL);
  wire wr_stat = AVS_WRITE & (AVS_ADDRESS == ADDR_STATUS);
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      uv_flag_ff <= 1'b0;
      por_flag_ff <= 1'b0;
      prog_ff <= 1'b0;
      soft_en_ff <= 1'b0;
    end else if (CE) begin
      prog_ff <= PROG_MODE;
      // hardware clear wins over software set
      if (uv_trip || por_s || prog_exit) begin
        uv_flag_ff <= 1'b0;
      end else if (wr_stat && AVS_WRITEDATA[ST_UVFLAG_BIT]) begin
        uv_flag_ff <= 1'b1;
      end
      if (por_s || prog_exit) begin
        por_flag_ff <= 1'b0;
      end else if (wr_stat && AVS_WRITEDATA[ST_PORFLAG_BIT]) begin
        por_flag_ff <= 1'b1;
      end
      if (wr_ctrl) begin
        soft_en_ff <= AVS_WRITEDATA[CTRL_SOFT_EN_BIT];
      end
    end
  end

  // ****************************************
  // wake stretch for off-in-sleep mode
  // ****************************************
  // detector is off while asleep, so after wake the core waits for it to be
  // ready again; in the other modes sleep gating is left to the core
  wire nxt_waking = (SLEEP & mode_slp) | (waking_ff & ~wake_ok);
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      waking_ff <= 1'b0;
    end else if (CE) begin
      waking_ff <= nxt_waking;
    end
  end

  // ****************************************
  // avalon read path, one wait cycle on reads
  // ****************************************
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_READY_BIT] = ready_s;
    status_word[ST_UVFLAG_BIT] = uv_flag_ff;
    status_word[ST_PORFLAG_BIT] = por_flag_ff;
    status_word[ST_ACTIVE_BIT] = prot_active;
    status_word[ST_RUN_BIT] = state_ff == ST_RUN;
    status_word[ST_MODE_LSB +: MODE_W] = UNDERVOLTAGE_MODE_SELECT;
  end
  wire [31:0] ctrl_word = {31'h0, soft_en_ff};
  wire [31:0] rd_mux = (AVS_ADDRESS == ADDR_CTRL) ? ctrl_word :
                       (AVS_ADDRESS == ADDR_STATUS) ? status_word : UNMAPPED_DATA;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_valid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (CE) begin
      rd_valid_ff <= AVS_READ & ~rd_valid_ff;
      if (AVS_READ && !rd_valid_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end
  assign AVS_WAITREQUEST = AVS_READ & ~rd_valid_ff;
  assign AVS_READDATA = rdata_ff;

  // ****************************************
  // outputs
  // ****************************************
  assign UV_DET_ENABLE = det_en;
  assign UV_LEVEL = UNDERVOLTAGE_LEVEL_SELECT;
  assign CORE_RESET_N = state_ff == ST_RUN;
  // sleep gating belongs to the core; here only off-in-sleep stalls wake
  assign CORE_RUN = (state_ff == ST_RUN) & ~waking_ff;

  // ****************************************
  // checks
  // ****************************************
  AST_POR_HOLDS: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && por_s |=> !CORE_RESET_N) else $error("core left reset during power-on");
  AST_UV_CLEARS: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && uv_trip |=> !uv_flag_ff && !CORE_RESET_N) else $error("undervoltage trip missed");
  AST_OFF_MODE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    UNDERVOLTAGE_MODE_SELECT == MODE_ALWAYS_OFF |-> !UV_DET_ENABLE) else $error("detector on in off mode");
  AST_FORCED_ON: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    mode_on |-> UV_DET_ENABLE) else $error("detector not forced on");
  AST_LEVEL_PASS: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    UV_LEVEL == UNDERVOLTAGE_LEVEL_SELECT) else $error("level not passed");
  AST_RUN_NEEDS_PIN: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && $rose(CORE_RESET_N) |-> $past(pin_n_s)) else $error("run with pin held");
  AST_POWER_UP_DELAY_TIMER_HOLD: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    state_ff == ST_POWER_UP_DELAY_TIMER |-> !CORE_RESET_N) else $error("core out of reset in delay");
  AST_ONWAIT: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && $rose(CORE_RESET_N) && mode_on |-> $past(ready_s)) else $error("start without ready");
  AST_EXEC_DELAY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && state_ff == ST_WAIT && nxt_state == ST_RUN |-> $past(cnt_go, 9)) else $error("exec delay short");
  AST_SW_SLEEP: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    mode_sw |-> UV_DET_ENABLE == soft_en_ff) else $error("sleep changed software mode");

  // ****************************************
  // checks on sequencing and sleep
  // ****************************************
  // a released power event with a delay selected must enter the delay
  AST_POWER_UP_DELAY_TIMER_START: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && state_ff == ST_HOLD && !power_event && power_up_delay_timer_en |=> state_ff == ST_POWER_UP_DELAY_TIMER) else $error("delay skipped");
  // with the selection at zero the sequence goes straight to the wait
  AST_NO_POWER_UP_DELAY_TIMER: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && state_ff == ST_HOLD && !power_event && !power_up_delay_timer_en |=> state_ff == ST_WAIT) else $error("delay not bypassed");
  // the delay is not cut short by the pin or the other sources
  AST_POWER_UP_DELAY_TIMER_RUNS_ON: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && state_ff == ST_POWER_UP_DELAY_TIMER && power_up_delay_timer_busy && !power_event |=> state_ff == ST_POWER_UP_DELAY_TIMER) else $error("delay cut short");
  // execution only ever starts from the counted wait
  AST_RUN_FROM_WAIT: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && $rose(CORE_RESET_N) |-> $past(state_ff) == ST_WAIT) else $error("run without exec wait");
  // any of the level or pulse sources pulls the core back into reset
  AST_OTHER_SRC: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && other_src |=> !CORE_RESET_N) else $error("source did not reset core");
  // programming holds the core, and its exit restarts like a power-on
  AST_PROG_HOLD: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && PROG_MODE |=> !CORE_RESET_N) else $error("core ran while programming");
  AST_PROG_EXIT: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && prog_exit |=> state_ff == ST_HOLD && !por_flag_ff && !uv_flag_ff) else $error("exit not like power-on");
  // software mode never waits for the detector before counting
  AST_SW_START: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && mode_sw && state_ff == ST_WAIT && pin_n_s && !other_src && !power_event |=> exec_cnt_ff != 4'h0)
    else $error("software mode start waited");
  // off-in-sleep: detector off asleep, core stalled, wake needs ready
  AST_SLEEP_OFF: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    mode_slp && SLEEP |-> !UV_DET_ENABLE) else $error("detector on asleep");
  AST_SLEEP_STALL: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && mode_slp && SLEEP |=> !CORE_RUN) else $error("core ran asleep");
  AST_WAKE_READY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CE && mode_slp && $rose(CORE_RUN) |-> $past(ready_s) && !$past(below_s)) else $error("woke before ready");
  // the active flag cannot show while the detector is not ready
  AST_READY_ACTIVE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !ready_s |-> !status_word[ST_ACTIVE_BIT]) else $error("active before ready");
  // nothing trips in the always-off mode, whatever the comparator says
  AST_OFF_NO_TRIP: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    UNDERVOLTAGE_MODE_SELECT == MODE_ALWAYS_OFF |-> !uv_trip) else $error("trip in off mode");
endmodule // rbs_sequencer

// File: hdl/rbs_sync.sv
`timescale 1ns/1ns
module rbs_sync
  import rbs_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // levels
  rbs_sync_if.syn sig
);
  // ****************************************
  // two-stage synchroniser per bit
  // ****************************************
  localparam int unsigned W = $bits(sig.raw);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else if (ce) begin
          meta_ff[gi] <= sig.raw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate
  assign sig.synced = sync_ff;
endmodule // rbs_sync

// File: hdl/rbs_timer.sv
`timescale 1ns/1ns
module rbs_timer
  import rbs_pkg::*;
#(
  parameter int unsigned CW = 32
) (
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic [CW-1:0] load,
  output logic busy
);
  // ****************************************
  // down counter, busy while nonzero
  // ****************************************
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  assign nxt_cnt = start ? load : (cnt_ff != '0 ? cnt_ff - 1'b1 : cnt_ff);
  assign busy = (cnt_ff != '0);
  // counter register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // rbs_timer

// File: inc/rbs_pkg.sv
package rbs_pkg;
  // ****************************************
  // undervoltage mode encodings
  // ****************************************
  localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
  localparam logic [1:0] MODE_OFF_SLEEP = 2'h2;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_ALWAYS_OFF = 2'h0;
  localparam logic [1:0] POWER_UP_DELAY_TIMER_DISABLED = 2'h0;
  localparam int unsigned MODE_W = 2;
  localparam int unsigned LEVEL_W = 2;
  localparam int unsigned SEL_W = 2;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLOCK_MHZ = 250;
  localparam int unsigned POWER_UP_DELAY_TIMER_MAX_MS = 64;
  localparam longint unsigned POWER_UP_DELAY_TIMER_MAX_CYC = longint'(POWER_UP_DELAY_TIMER_MAX_MS) * 1000 * CLOCK_MHZ;
  localparam int unsigned EXEC_DELAY_CYC = 10;
  localparam int unsigned SYNC_STAGES = 2;
  // ****************************************
  // register bus map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int unsigned CTRL_SOFT_EN_BIT = 0;
  localparam int unsigned ST_READY_BIT = 0;
  localparam int unsigned ST_UVFLAG_BIT = 1;
  localparam int unsigned ST_PORFLAG_BIT = 2;
  localparam int unsigned ST_ACTIVE_BIT = 3;
  localparam int unsigned ST_RUN_BIT = 4;
  localparam int unsigned ST_MODE_LSB = 8;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_POWER_UP_DELAY_TIMER = 2'b01,
    ST_WAIT = 2'b10,
    ST_RUN  = 2'b11
  } rbs_state_t;
endpackage

// File: inc/rbs_sync_if.sv
`timescale 1ns/1ns
interface rbs_sync_if #(parameter int unsigned WIDTH = 4);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport src (output raw, input synced);
  modport syn (input raw, output synced);
endinterface

// File: testbench/rbs_analog_model.sv
`timescale 1ns/1ns
module rbs_analog_model #(
  parameter int unsigned READY_DLY = 8,
  parameter int unsigned FILTER_CYC = 4
) (
  // clock and commands from the bench
  input wire logic clk,
  input wire logic por_req,
  input wire logic supply_low,
  input wire logic pin_hold,
  input wire logic ready_stall,
  // detector power from the block
  input wire logic det_enable,
  // analog side outputs
  output logic por_active,
  output logic below_filtered,
  output logic det_ready,
  output logic pin_n
);
  int unsigned rdy_cnt;
  int unsigned low_cnt;
  // weak pull-up on the pin: a released pin reads high
  assign pin_n = ~pin_hold;
  // ready only after the detector has been powered for a while;
  // comparator is not gated by enable, so the block must ignore it
  always @(posedge clk) begin
    rdy_cnt <= det_enable ? ((rdy_cnt < READY_DLY) ? rdy_cnt + 1 : rdy_cnt) : 0;
    det_ready <= det_enable && !ready_stall && (rdy_cnt >= READY_DLY);
    low_cnt <= supply_low ? low_cnt + 1 : 0;
    below_filtered <= (low_cnt > FILTER_CYC);
    por_active <= por_req;
  end
endmodule // rbs_analog_model

// File: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import rbs_pkg::*;
  localparam int DELAY_SIM = 20;
  logic clk, rst_n, por_req, supply_low, pin_hold, ready_stall, sleep, prog;
  logic avs_read, avs_write, avs_waitrequest, det_en, core_rst_n, core_run, por_a, below, ready, pin_n;
  logic [3:0] src, avs_address;
  logic [1:0] mode, level, dsel, uv_level;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int err_count, total_checks, cyc, n, i;

  rbs_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(DELAY_SIM), .EXEC_CYCLES(EXEC_DELAY_CYC)) i_dut (
    .CLOCK(clk), .RESET_N(rst_n), .CE(1'b1), .POR_ACTIVE(por_a), .UV_BELOW_FILTERED(below),
    .UV_DET_READY(ready), .EXTERNAL_RESET_PIN_N(pin_n), .WDT_RESET(src[0]), .RESET_INSTR(src[1]),
    .STACK_OVERFLOW(src[2]), .STACK_UNDERFLOW(src[3]), .PROG_MODE(prog), .SLEEP(sleep),
    .UNDERVOLTAGE_MODE_SELECT(mode), .UNDERVOLTAGE_LEVEL_SELECT(level), .POWER_UP_DELAY_SELECT(dsel),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .UV_DET_ENABLE(det_en),
    .UV_LEVEL(uv_level), .CORE_RESET_N(core_rst_n), .CORE_RUN(core_run));

  rbs_analog_model i_analog (
    .clk(clk), .por_req(por_req), .supply_low(supply_low), .pin_hold(pin_hold), .ready_stall(ready_stall),
    .det_enable(det_en), .por_active(por_a), .below_filtered(below), .det_ready(ready), .pin_n(pin_n));

  // ****************************************
  // bus and check tasks
  // ****************************************
  // request rises after a rising edge and stands until waitrequest is seen low
  // at one; data is taken and the request dropped at that same edge
  task bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_read <= 1'b1;
    avs_address <= a;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_cnt(input string nm, input int g, input int lo, input int hi);
    total_checks++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // cycles until core reset (which=0) or run (which=1) reaches v
  task wait_core(input bit which, input logic v, input int lim, output int k);
    k = 0;
    while (((which ? core_run : core_rst_n) !== v) && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task por_pulse;
    @(posedge clk) por_req <= 1'b1;
    tick(5);
    por_req <= 1'b0;
  endtask
  task report_and_stop;
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // clock, and a ceiling well above the expected run length
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {rst_n, por_req, supply_low, pin_hold, ready_stall, sleep, prog, avs_read, avs_write} = '0;
    {src, avs_address, level, avs_writedata} = '0;
    mode = MODE_SOFTWARE;
    dsel = 2'h1;
    tick(10);
    @(negedge clk) chk_bit("held in reset", 1'b0, core_rst_n);
    @(posedge clk) rst_n <= 1'b1;
    wait_core(0, 1'b1, 80, n); chk_cnt("power-up", n, DELAY_SIM + 10, DELAY_SIM + 25);
    for (i = 0; i < 4; i++) begin
      @(posedge clk) level <= i[1:0];
      @(negedge clk) chk_word("level", 32'(i), {30'h0, uv_level});
    end
    for (i = 0; i < 4; i++) begin
      @(posedge clk) mode <= i[1:0];
      bus_rd(ADDR_STATUS, rd); chk_word("mode field", 32'(i), {30'h0, rd[ST_MODE_LSB+:2]});
      chk_bit("detector on", logic'(i >= 2), det_en);
    end
    // software mode: enable bit drives the detector, sleep changes nothing
    @(posedge clk) mode <= MODE_SOFTWARE;
    bus_wr(ADDR_CTRL, 32'h1); bus_rd(ADDR_CTRL, rd); chk_word("ctrl", 32'h1, rd);
    chk_bit("soft enable", 1'b1, det_en);
    @(posedge clk) sleep <= 1'b1;
    tick(20); chk_bit("soft enable asleep", 1'b1, det_en);
    bus_rd(ADDR_STATUS, rd); chk_bit("ready flag", 1'b1, rd[ST_READY_BIT]);
    chk_bit("active flag", 1'b1, rd[ST_ACTIVE_BIT]);
    chk_bit("run flag", 1'b1, rd[ST_RUN_BIT]);
    sleep <= 1'b0;
    bus_rd(4'hc, rd); chk_word("unmapped", UNMAPPED_DATA, rd);
    // always off: enable bit ignored, no trip
    @(posedge clk) mode <= MODE_ALWAYS_OFF;
    tick(2); chk_bit("off enable", 1'b0, det_en);
    supply_low <= 1'b1;
    tick(20); chk_bit("off no trip", 1'b1, core_rst_n);
    supply_low <= 1'b0;
    // off in sleep: no trip asleep, wake waits for ready
    tick(6); mode <= MODE_OFF_SLEEP; sleep <= 1'b1;
    tick(4); chk_bit("sleep enable", 1'b0, det_en);
    supply_low <= 1'b1;
    tick(20); chk_bit("sleep no trip", 1'b1, core_rst_n);
    chk_bit("no run asleep", 1'b0, core_run);
    supply_low <= 1'b0;
    tick(6); sleep <= 1'b0;
    wait_core(1, 1'b1, 40, n); chk_cnt("wake delay", n, 8, 39);
    // always on: trips in sleep and clears the flag
    @(posedge clk) mode <= MODE_ALWAYS_ON;
    tick(20); bus_wr(ADDR_STATUS, 32'h0000_0006);
    @(posedge clk) sleep <= 1'b1;
    tick(2); chk_bit("on enable asleep", 1'b1, det_en);
    supply_low <= 1'b1;
    wait_core(0, 1'b0, 20, n); chk_cnt("trip", n, 4, 15);
    bus_rd(ADDR_STATUS, rd); chk_bit("uv flag", 1'b0, rd[ST_UVFLAG_BIT]);
    supply_low <= 1'b0; sleep <= 1'b0;
    wait_core(0, 1'b1, 80, n); chk_cnt("undervoltage restart", n, DELAY_SIM + 10, 50);
    // supply below minimum, then start waits for ready
    @(posedge clk) por_req <= 1'b1; ready_stall <= 1'b1;
    tick(60); chk_bit("por hold", 1'b0, core_rst_n);
    por_req <= 1'b0;
    tick(60); chk_bit("wait ready", 1'b0, core_rst_n);
    ready_stall <= 1'b0;
    wait_core(0, 1'b1, 60, n); chk_cnt("ready start", n, 10, 20);
    bus_rd(ADDR_STATUS, rd); chk_bit("ready before run", 1'b1, rd[ST_READY_BIT]);
    // programming exit behaves as power-on
    @(posedge clk) mode <= MODE_SOFTWARE;
    bus_wr(ADDR_STATUS, 32'h0000_0006);
    @(posedge clk) prog <= 1'b1;
    tick(6); chk_bit("prog reset", 1'b0, core_rst_n);
    prog <= 1'b0;
    wait_core(0, 1'b1, 80, n); chk_cnt("prog exit", n, DELAY_SIM + 10, 45);
    bus_rd(ADDR_STATUS, rd); chk_bit("power flag", 1'b0, rd[ST_PORFLAG_BIT]);
    // pin held past the delay: execution ten cycles after release
    @(posedge clk) pin_hold <= 1'b1;
    por_pulse();
    tick(60); chk_bit("pin hold", 1'b0, core_rst_n);
    pin_hold <= 1'b0;
    wait_core(0, 1'b1, 40, n); chk_cnt("pin release", n, 10, 15);
    // the four internal request sources
    for (i = 0; i < 4; i++) begin
      @(posedge clk) src <= 4'h1 << i;
      tick(6); chk_bit("source reset", 1'b0, core_rst_n);
      src <= 4'h0;
      wait_core(0, 1'b1, 40, n); chk_cnt("source restart", n, 10, 20);
    end
    // delay selection off: no extra delay
    @(posedge clk) dsel <= POWER_UP_DELAY_TIMER_DISABLED;
    por_pulse();
    wait_core(0, 1'b1, 40, n); chk_cnt("no delay", n, 10, 18);
    report_and_stop();
  end
endmodule // tb_top
